// ==== design/rtc_cmd.sv ====
/*
  Command interpreter of the RF transceiver: takes serial command bytes,
  selects protocol, modulation, subcarrier and rate, reads and writes the
  configuration register and writes the timing register.
  Assumes a host framing each command with ser_sel and shifting bits MSB
  first on rising edges of ser_clk; all three pins are asynchronous.
*/
// Overview of operation
// - 0x71 returns configuration register to host
// - 0x7B then 13 bits loads timing register
// - 0x7D then data writes configuration register
// - 0x4E selects 14443 A, 100%, AM, high
// - Protocol bits 011 select 15693 one-of-256
// - Protocol bits 010 select 15693 one-of-four
// - 15693 rates: 6.67 FM, 6.62 AM, 26.69
// - Configuration fields: idle, protocol, mod, sub, rate, decoder
// - Protocol codes: three modes, three reserved, 000 and 001 refused
// - Power-up configuration is 00100010
// - Timing offset sets decoder sampling point
// - Delay counts from transmit end to reply
// - Debug bit puts sample pulses on error pin
// - Each offset unit adds 295 ns
// - Timing value kept until 0x7B rewrites it or rst_n clears it
// - Command bit 1 selects low or high rate
`timescale 1ns/10ps
`include "rtc_cfg.svh"
module rtc_cmd #(
  parameter int SAMPLE_PERIOD = `RTC_SAMPLE_PERIOD
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ser_sel_pin,
  input wire logic ser_clk_pin,
  input wire logic ser_data_pin,
  output logic ser_dout,
  output logic ser_dout_oe,
  input wire logic tx_end,
  input wire logic rx_done,
  input wire logic dec_err,
  output logic m_err,
  output logic sample_pulse,
  output logic [7:0] cfg_out,
  output logic [6:0] sample_offset_count,
  output logic sample_pulse_debug_enable,
  output rtc_pkg::rtc_rate_t data_rate
);
  typedef struct packed {
    rtc_pkg::rtc_phase_t ph;
    logic sclk_prev;
    logic [3:0] cnt;
    logic [12:0] sh;
    logic [7:0] cfg;
    logic [12:0] tim;
    logic dout;
    logic doe;
    logic merr;
    rtc_pkg::rtc_rate_t rate;
  } rtc_st_t;
  rtc_st_t s_q;
  rtc_st_t s_d;
  logic [2:0] pins_s;
  logic sel;
  logic sclk;
  logic sdat;
  logic rise;
  logic cmd_fire;
  logic [7:0] cmd_val;
  logic tim_load;
  logic cfg_load;
  logic [7:0] byte_in;
  logic [12:0] word_in;
  logic sample_raw;

  // ==========================================================
  // Decode helpers
  function automatic logic par_ok(input logic [7:0] c);
    par_ok = ~(^c);
  endfunction : par_ok

  function automatic logic proto_ok(input logic [7:0] c);
    logic [2:0] p;
    p = c[`RTC_PROT_HI:`RTC_PROT_LO];
    proto_ok = 1'b0;
    if (!c[`RTC_IDLE_BIT]) begin
      if (p == `RTC_PROT_1OF4 || p == `RTC_PROT_1OF256) begin
        proto_ok = 1'b1;
      end
      if (c == `RTC_CMD_14443) begin
        proto_ok = 1'b1;
      end
    end
  endfunction : proto_ok

  function automatic rtc_pkg::rtc_rate_t rate_of(input logic [7:0] c);
    if (c[`RTC_PROT_HI:`RTC_PROT_LO] == `RTC_PROT_14443) begin
      rate_of = rtc_pkg::RTC_R_105K94;
    end else if (c[`RTC_RATE_BIT]) begin
      rate_of = rtc_pkg::RTC_R_26K69;
    end else if (c[`RTC_SUB_BIT]) begin
      rate_of = rtc_pkg::RTC_R_6K62;
    end else begin
      rate_of = rtc_pkg::RTC_R_6K67;
    end
  endfunction : rate_of

  // ==========================================================
  // Pin synchronisers
  rtc_sync #(
    .WIDTH(3)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in({ser_sel_pin, ser_clk_pin, ser_data_pin}),
    .sync_out(pins_s)
  );
  assign sel = pins_s[2];
  assign sclk = pins_s[1];
  assign sdat = pins_s[0];

  // ==========================================================
  // Decoder sampling pulses
  rtc_sample_gen #(
    .SAMPLE_PERIOD(SAMPLE_PERIOD)
  ) u_sample (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tx_end(tx_end),
    .rx_done(rx_done),
    .sample_offset_count(s_q.tim[`RTC_OFS_HI:0]),
    .sample_pulse(sample_raw)
  );

  // ==========================================================
  // Command frame
  always_comb begin
    s_d = s_q;
    s_d.sclk_prev = sclk;
    rise = sclk & ~s_q.sclk_prev;
    byte_in = {s_q.sh[6:0], sdat};
    word_in = {s_q.sh[11:0], sdat};
    cmd_fire = 1'b0;
    cmd_val = byte_in;
    tim_load = 1'b0;
    cfg_load = 1'b0;
    if (!sel) begin
      s_d.ph = rtc_pkg::RTC_IDLE;
      s_d.doe = 1'b0;
      s_d.cnt = '0;
    end else begin
      case (s_q.ph)
        rtc_pkg::RTC_IDLE: begin
          s_d.ph = rtc_pkg::RTC_CMD;
          s_d.cnt = '0;
        end
        rtc_pkg::RTC_CMD: begin
          if (rise) begin
            s_d.sh = word_in;
            s_d.cnt = s_q.cnt + 4'h1;
            if (s_q.cnt == `RTC_BYTE_LAST) begin
              cmd_fire = 1'b1;
              s_d.cnt = '0;
              s_d.ph = rtc_pkg::RTC_DONE;
              if (par_ok(cmd_val)) begin
                case (cmd_val)
                  `RTC_CMD_READ_CFG: begin
                    s_d.ph = rtc_pkg::RTC_RDCFG;
                    s_d.sh = {5'h00, s_q.cfg};
                    s_d.dout = s_q.cfg[7];
                    s_d.doe = 1'b1;
                  end
                  `RTC_CMD_WRITE_TIM: s_d.ph = rtc_pkg::RTC_WRTIM;
                  `RTC_CMD_WRITE_CFG: s_d.ph = rtc_pkg::RTC_WRCFG;
                  default: begin
                    if (proto_ok(cmd_val)) begin
                      // Manchester decoder bit is left as it is
                      s_d.cfg[7:1] = cmd_val[7:1];
                    end
                  end
                endcase
              end
            end
          end
        end
        rtc_pkg::RTC_RDCFG: begin
          if (rise) begin
            s_d.cnt = s_q.cnt + 4'h1;
            s_d.sh = {s_q.sh[11:0], 1'b0};
            s_d.dout = s_q.sh[6];
            if (s_q.cnt == `RTC_BYTE_LAST) begin
              s_d.ph = rtc_pkg::RTC_DONE;
              s_d.doe = 1'b0;
              s_d.dout = 1'b0;
            end
          end
        end
        rtc_pkg::RTC_WRCFG: begin
          if (rise) begin
            s_d.sh = word_in;
            s_d.cnt = s_q.cnt + 4'h1;
            if (s_q.cnt == `RTC_BYTE_LAST) begin
              cfg_load = 1'b1;
              s_d.cfg = byte_in;
              s_d.ph = rtc_pkg::RTC_DONE;
            end
          end
        end
        rtc_pkg::RTC_WRTIM: begin
          if (rise) begin
            s_d.sh = word_in;
            s_d.cnt = s_q.cnt + 4'h1;
            if (s_q.cnt == `RTC_TIM_LAST) begin
              tim_load = 1'b1;
              s_d.tim = word_in;
              s_d.ph = rtc_pkg::RTC_DONE;
            end
          end
        end
        rtc_pkg::RTC_DONE: s_d.ph = rtc_pkg::RTC_DONE;
        default: s_d.ph = rtc_pkg::RTC_IDLE;
      endcase
    end
    s_d.rate = rate_of(s_d.cfg);
    s_d.merr = s_d.tim[`RTC_DBG_BIT] ? sample_raw : dec_err;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{
        ph: rtc_pkg::RTC_IDLE,
        sclk_prev: 1'b0,
        cnt: 4'h0,
        sh: 13'h0000,
        cfg: `RTC_CFG_RESET,
        tim: `RTC_TIM_RESET,
        dout: 1'b0,
        doe: 1'b0,
        merr: 1'b0,
        rate: rtc_pkg::RTC_R_26K69
      };
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  assign ser_dout = s_q.dout;
  assign ser_dout_oe = s_q.doe;
  assign m_err = s_q.merr;
  assign sample_pulse = sample_raw;
  assign cfg_out = s_q.cfg;
  assign sample_offset_count = s_q.tim[`RTC_OFS_HI:0];
  assign sample_pulse_debug_enable = s_q.tim[`RTC_DBG_BIT];
  assign data_rate = s_q.rate;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_read_cfg;
    logic [7:0] c;
    (cmd_fire && cmd_val == `RTC_CMD_READ_CFG, c = s_q.cfg) |=>
      ser_dout_oe && ser_dout == c[7] && s_q.ph == rtc_pkg::RTC_RDCFG;
  endproperty
  a_read_cfg: assert property (p_read_cfg) else $error("read command not answered");

  property p_tim_write;
    tim_load |=> s_q.tim == $past(word_in) && s_q.ph == rtc_pkg::RTC_DONE;
  endproperty
  a_tim_write: assert property (p_tim_write) else $error("timing write lost");

  property p_cfg_write;
    cfg_load |=> cfg_out == $past(byte_in);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config write lost");

  property p_14443;
    cmd_fire && cmd_val == `RTC_CMD_14443 |=>
      cfg_out[6:1] == 6'h27 ##1 data_rate == rtc_pkg::RTC_R_105K94;
  endproperty
  a_14443: assert property (p_14443) else $error("14443 select wrong");

  property p_15693;
    cmd_fire && par_ok(cmd_val) && !cmd_val[7] && cmd_val[6:5] == 2'h1 |=>
      cfg_out[6:4] == $past(cmd_val[6:4]) && cfg_out[1] == $past(cmd_val[1]);
  endproperty
  a_15693: assert property (p_15693) else $error("15693 select wrong");

  property p_bad_cmd;
    cmd_fire && !(par_ok(cmd_val) && (proto_ok(cmd_val) || cmd_val == `RTC_CMD_READ_CFG
      || cmd_val == `RTC_CMD_WRITE_CFG || cmd_val == `RTC_CMD_WRITE_TIM)) |=>
      $stable(cfg_out) && $stable(s_q.tim) && s_q.ph != rtc_pkg::RTC_WRTIM;
  endproperty
  a_bad_cmd: assert property (p_bad_cmd) else $error("ignored command changed state");

  property p_tim_hold;
    !tim_load |=> $stable(s_q.tim);
  endproperty
  a_tim_hold: assert property (p_tim_hold) else $error("timing changed without write");

  property p_debug_pin;
    sample_pulse_debug_enable && $past(sample_pulse_debug_enable) |-> m_err == $past(sample_raw);
  endproperty
  a_debug_pin: assert property (p_debug_pin) else $error("debug pin not sampling pulses");

  property p_rate;
    data_rate == rate_of(cfg_out);
  endproperty
  a_rate: assert property (p_rate) else $error("rate does not follow config");

  property p_read_end;
    s_q.ph == rtc_pkg::RTC_RDCFG && sel && rise && s_q.cnt == `RTC_BYTE_LAST |=>
      !ser_dout_oe && !ser_dout && s_q.ph == rtc_pkg::RTC_DONE;
  endproperty
  a_read_end: assert property (p_read_end) else $error("read drive not released");

  property p_abort;
    !sel |=> !ser_dout_oe && s_q.ph == rtc_pkg::RTC_IDLE && !tim_load && !cfg_load;
  endproperty
  a_abort: assert property (p_abort) else $error("deselect did not end the frame");

  property p_bad_parity;
    cmd_fire && !par_ok(cmd_val) |=> s_q.ph == rtc_pkg::RTC_DONE && !ser_dout_oe;
  endproperty
  a_bad_parity: assert property (p_bad_parity) else $error("odd parity byte obeyed");

  property p_reserved;
    cmd_fire && cmd_val[`RTC_PROT_HI:`RTC_PROT_LO] > `RTC_PROT_14443 |=> $stable(cfg_out);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved protocol applied");

  property p_keep_decoder;
    cmd_fire && par_ok(cmd_val) && proto_ok(cmd_val) |=> $stable(cfg_out[`RTC_MAN_BIT]);
  endproperty
  a_keep_decoder: assert property (p_keep_decoder) else $error("decoder bit changed");

  c_read: cover property (cmd_fire && cmd_val == `RTC_CMD_READ_CFG ##[1:200] !ser_dout_oe);
  c_tim: cover property (tim_load);
  c_cfg: cover property (cfg_load);
  c_proto: cover property (cmd_fire && proto_ok(cmd_val) && par_ok(cmd_val));
  c_debug: cover property (sample_pulse_debug_enable && sample_raw);
endmodule : rtc_cmd

// ==== design/rtc_cfg.svh ====
/*
  Constants of the command interpreter: command codes, field positions,
  reset values and timing figures.
  Assumes inclusion by bare name from design files only.
*/
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH
// ==========================================================
// Command codes
`define RTC_CMD_READ_CFG 8'h71
`define RTC_CMD_WRITE_TIM 8'h7B
`define RTC_CMD_WRITE_CFG 8'h7D
`define RTC_CMD_14443 8'h4E
// ==========================================================
// Field positions and protocol codes
`define RTC_IDLE_BIT 7
`define RTC_PROT_HI 6
`define RTC_PROT_LO 4
`define RTC_MOD_BIT 3
`define RTC_SUB_BIT 2
`define RTC_RATE_BIT 1
`define RTC_MAN_BIT 0
`define RTC_DBG_BIT 7
`define RTC_OFS_HI 6
`define RTC_PROT_1OF4 3'h2
`define RTC_PROT_1OF256 3'h3
`define RTC_PROT_14443 3'h4
// ==========================================================
// Reset values and bit counts
`define RTC_CFG_RESET 8'h22
`define RTC_TIM_RESET 13'h0000
`define RTC_BYTE_LAST 4'h7
`define RTC_TIM_LAST 4'hC
// ==========================================================
// Timing
`define RTC_UNIT_NS 295
`define RTC_CLK_NS 100
`define RTC_SAMPLE_PERIOD 8
`endif

// ==== design/rtc_pkg.sv ====
/*
  Types shared by the command interpreter modules.
  Assumes rtc_cfg.svh for the numeric constants.
*/
package rtc_pkg;
  // ==========================================================
  // Command frame phases
  typedef enum logic [5:0] {
    RTC_IDLE = 6'h01,
    RTC_CMD = 6'h02,
    RTC_RDCFG = 6'h04,
    RTC_WRCFG = 6'h08,
    RTC_WRTIM = 6'h10,
    RTC_DONE = 6'h20
  } rtc_phase_t;
  // ==========================================================
  // Reader data rate in force
  typedef enum logic [1:0] {
    RTC_R_6K67 = 2'h0,
    RTC_R_6K62 = 2'h1,
    RTC_R_26K69 = 2'h2,
    RTC_R_105K94 = 2'h3
  } rtc_rate_t;
  // ==========================================================
  // Sample generator phases
  typedef enum logic [2:0] {
    RTC_SG_IDLE = 3'h1,
    RTC_SG_WAIT = 3'h2,
    RTC_SG_RUN = 3'h4
  } rtc_sg_phase_t;
endpackage : rtc_pkg

// ==== design/rtc_sync.sv ====
/*
  Two flip-flop synchroniser for a group of pin inputs.
  Assumes the inputs are levels from outside the sys_clk domain.
*/
`timescale 1ns/10ps
module rtc_sync #(
  parameter int WIDTH = 3
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } rtc_sync_st_t;
  rtc_sync_st_t s_q;
  rtc_sync_st_t s_d;
  // ==========================================================
  // Stages
  always_comb begin
    s_d.meta = async_in;
    s_d.sync = s_q.meta;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign sync_out = s_q.sync;
endmodule : rtc_sync

// ==== design/rtc_sample_gen.sv ====
/*
  Decoder sampling pulse generator: waits the offset delay after the end
  of transmission, then pulses every SAMPLE_PERIOD cycles until rx_done.
  Assumes tx_end and rx_done are one-cycle pulses on sys_clk.
*/
`timescale 1ns/10ps
`include "rtc_cfg.svh"
module rtc_sample_gen #(
  parameter int SAMPLE_PERIOD = `RTC_SAMPLE_PERIOD
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic tx_end,
  input wire logic rx_done,
  input wire logic [6:0] sample_offset_count,
  output logic sample_pulse
);
  typedef struct packed {
    rtc_pkg::rtc_sg_phase_t ph;
    logic [15:0] el_ns;
    logic [7:0] per;
    logic pulse;
  } rtc_sg_st_t;
  rtc_sg_st_t s_q;
  rtc_sg_st_t s_d;
  logic [15:0] target_ns;
  // ==========================================================
  // Delay is counted in ns so the 295 ns unit needs no rounding
  always_comb begin
    target_ns = 16'(sample_offset_count) * 16'(`RTC_UNIT_NS);
    s_d = s_q;
    s_d.pulse = 1'b0;
    case (s_q.ph)
      rtc_pkg::RTC_SG_IDLE: begin
        s_d.el_ns = '0;
      end
      rtc_pkg::RTC_SG_WAIT: begin
        s_d.el_ns = s_q.el_ns + 16'(`RTC_CLK_NS);
        if (s_q.el_ns >= target_ns) begin
          s_d.ph = rtc_pkg::RTC_SG_RUN;
          s_d.pulse = 1'b1;
          s_d.per = '0;
        end
      end
      rtc_pkg::RTC_SG_RUN: begin
        s_d.per = s_q.per + 8'h01;
        if (s_q.per == 8'(SAMPLE_PERIOD - 1)) begin
          s_d.per = '0;
          s_d.pulse = 1'b1;
        end
      end
      default: s_d.ph = rtc_pkg::RTC_SG_IDLE;
    endcase
    if (rx_done) begin
      s_d.ph = rtc_pkg::RTC_SG_IDLE;
    end
    if (tx_end) begin
      s_d.ph = rtc_pkg::RTC_SG_WAIT;
      s_d.el_ns = '0;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{ph: rtc_pkg::RTC_SG_IDLE, el_ns: 16'h0000, per: 8'h00, pulse: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end
  assign sample_pulse = s_q.pulse;
endmodule : rtc_sample_gen

// ==== testbench/rtc_host_model.sv ====
/*
  Host controller model: frames serial command bytes for the interpreter.
  Assumes the bench calls frame() and that the device reads on sys_clk.
*/
`timescale 1ns/10ps
module rtc_host_model (
  input wire logic sys_clk,
  input wire logic ser_dout,
  input wire logic ser_dout_oe,
  output logic ser_sel_pin,
  output logic ser_clk_pin,
  output logic ser_data_pin
);
  // ==========================================================
  // Idle pins: clock stands low outside frames
  initial begin
    ser_sel_pin = 1'b0;
    ser_clk_pin = 1'b0;
    ser_data_pin = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : wt
  // ==========================================================
  // One frame of n bits, MSB first; hold sets the pace of the host
  task automatic frame(input logic [20:0] b, input int n, input int hold,
                       output logic [7:0] rd);
    rd = 8'h00;
    wt(1);
    ser_sel_pin = 1'b1;
    wt(4);
    for (int i = n - 1; i >= 0; i--) begin
      if (n - 1 - i >= 8) rd = {rd[6:0], ser_dout};
      ser_data_pin = b[i];
      wt(hold);
      ser_clk_pin = 1'b1;
      wt(hold);
      ser_clk_pin = 1'b0;
    end
    wt(hold);
    ser_sel_pin = 1'b0;
    // Released data line shows no stale value
    ser_data_pin = ~ser_data_pin;
    wt(4);
  endtask : frame
endmodule : rtc_host_model

// ==== testbench/rtc_cmd_tb.sv ====
/*
  Self-checking bench of the command interpreter.
  Assumes the host model and the design files are compiled before it.
*/
`timescale 1ns/10ps
module rtc_cmd_tb;
  localparam int SP = 6;
  logic sys_clk, rst_n, tx_end, rx_done, dec_err;
  logic ser_sel_pin, ser_clk_pin, ser_data_pin, ser_dout, ser_dout_oe, m_err, sample_pulse;
  logic sample_pulse_debug_enable;
  logic [7:0] cfg_out, rd;
  logic [6:0] sample_offset_count;
  rtc_pkg::rtc_rate_t data_rate;
  int err_total = 0;
  int total_checks = 0;
  int c, lo;
  // Command byte beside expected rate code; parity already even
  logic [9:0] rows [17] = '{{8'h21, 2'h0}, {8'h22, 2'h2}, {8'h24, 2'h1}, {8'h27, 2'h2},
    {8'h28, 2'h0}, {8'h2B, 2'h2}, {8'h2D, 2'h1}, {8'h2E, 2'h2}, {8'h30, 2'h0},
    {8'h33, 2'h2}, {8'h35, 2'h1}, {8'h36, 2'h2}, {8'h39, 2'h0}, {8'h3A, 2'h2},
    {8'h3C, 2'h1}, {8'h3F, 2'h2}, {8'h4E, 2'h3}};
  logic [7:0] bad [5] = '{8'h70, 8'h41, 8'h50, 8'h7E, 8'h00};
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  rtc_host_model u_host (.sys_clk(sys_clk), .ser_dout(ser_dout), .ser_dout_oe(ser_dout_oe),
    .ser_sel_pin(ser_sel_pin), .ser_clk_pin(ser_clk_pin), .ser_data_pin(ser_data_pin));
  rtc_cmd #(.SAMPLE_PERIOD(SP)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .ser_sel_pin(ser_sel_pin), .ser_clk_pin(ser_clk_pin), .ser_data_pin(ser_data_pin),
    .ser_dout(ser_dout), .ser_dout_oe(ser_dout_oe), .tx_end(tx_end), .rx_done(rx_done),
    .dec_err(dec_err), .m_err(m_err), .sample_pulse(sample_pulse), .cfg_out(cfg_out),
    .sample_offset_count(sample_offset_count),
    .sample_pulse_debug_enable(sample_pulse_debug_enable), .data_rate(data_rate));
  // ==========================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic send(input logic [20:0] b, input int n);
    u_host.frame(b, n, 4, rd);
  endtask : send
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    rst_n = 1'b1;
  endtask : do_reset
  // Pulse tx_end and count cycles to the first sampling strobe
  task automatic meas(input int off);
    tx_end = 1'b1;
    @(negedge sys_clk);
    tx_end = 1'b0;
    c = 1;
    while (sample_pulse !== 1'b1 && c < 2000) begin
      @(negedge sys_clk);
      c++;
    end
    lo = (off * 295 + 99) / 100;
    chk("first sample", 8'h01, 8'((c >= lo) && (c <= lo + 4)));
  endtask : meas
  task automatic stop_rx();
    rx_done = 1'b1;
    @(negedge sys_clk);
    rx_done = 1'b0;
    c = 0;
    repeat (30) begin
      @(negedge sys_clk);
      c += int'(sample_pulse === 1'b1);
    end
    chk("pulses after rx_done", 8'h00, 8'(c));
  endtask : stop_rx
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results
  initial begin
    repeat (50000) @(posedge sys_clk);
    err_total++;
    $display("watchdog expired");
    results();
  end
  // ==========================================================
  // Main sequence
  initial begin
    tx_end = 1'b0;
    rx_done = 1'b0;
    dec_err = 1'b0;
    do_reset();
    chk("cfg", 8'h22, cfg_out);
    chk("rate", 8'h02, 8'(data_rate));
    chk("offset", 8'h00, 8'(sample_offset_count));
    chk("oe", 8'h00, 8'(ser_dout_oe));
    $display("test reset done");
    foreach (rows[i]) begin
      send({13'h0000, rows[i][9:2]}, 8);
      chk("cfg", {rows[i][9:3], 1'b0}, cfg_out);
      chk("rate", 8'(rows[i][1:0]), 8'(data_rate));
    end
    $display("test protocol table done");
    send({5'h00, 8'h7D, 8'h3B}, 16);
    chk("cfg", 8'h3B, cfg_out);
    send({5'h00, 8'h71, 8'h00}, 16);
    chk("read data", 8'h3B, rd);
    chk("oe", 8'h00, 8'(ser_dout_oe));
    $display("test write and read done");
    foreach (bad[i]) begin
      send({13'h0000, bad[i]}, 8);
      chk("cfg", 8'h3B, cfg_out);
    end
    send({9'h000, 8'h7D, 4'hF}, 12);
    chk("cfg", 8'h3B, cfg_out);
    $display("test refusals done");
    send({8'h7B, 13'b1100000010010}, 21);
    chk("offset", 8'h12, 8'(sample_offset_count));
    chk("debug", 8'h00, 8'(sample_pulse_debug_enable));
    meas(18);
    @(negedge sys_clk);
    chk("m_err", 8'h00, 8'(m_err));
    c = 0;
    while (sample_pulse !== 1'b1 && c < 100) begin
      @(negedge sys_clk);
      c++;
    end
    chk("period", 8'(SP), 8'(c + 1));
    stop_rx();
    dec_err = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk("m_err", 8'h01, 8'(m_err));
    dec_err = 1'b0;
    $display("test timing done");
    send({8'h7B, 13'h0082}, 21);
    chk("debug", 8'h01, 8'(sample_pulse_debug_enable));
    meas(2);
    @(negedge sys_clk);
    chk("m_err", 8'h01, 8'(m_err));
    stop_rx();
    send({13'h0000, 8'h4E}, 8);
    chk("cfg", 8'h4F, cfg_out);
    chk("rate", 8'h03, 8'(data_rate));
    chk("offset", 8'h02, 8'(sample_offset_count));
    $display("test debug output done");
    do_reset();
    chk("cfg", 8'h22, cfg_out);
    chk("offset", 8'h00, 8'(sample_offset_count));
    u_host.frame({5'h00, 8'h7D, 8'h21}, 16, 7, rd);
    chk("cfg", 8'h21, cfg_out);
    chk("rate", 8'h00, 8'(data_rate));
    $display("test second reset done");
    results();
  end
endmodule : rtc_cmd_tb
